// ===== hw/duty_map.sv
`include "srv_regs.svh"
module duty_map (
  // Selection
  input  wire logic [1:0] max_sel,
  input  wire logic [3:0] val,
  // Result
  output logic [3:0]      duty
);
  import srv_pkg::*;
  logic [3:0] ramp;
  logic [3:0] cap;

  always_comb begin
    // Full-scale column: +2 offset, flat at Eh and at Fh near the top
    if (val == 4'hD) begin
      ramp = 4'hE;
    end else if (val > 4'hD) begin
      ramp = `SRV_VAL_FULL;
    end else begin
      ramp = val + `SRV_DUTY_BASE;
    end
    case (max_sel)
      2'h0:    cap = `SRV_CAP_00;
      2'h1:    cap = `SRV_CAP_01;
      2'h2:    cap = `SRV_CAP_10;
      default: cap = `SRV_CAP_11;
    endcase
    duty = (ramp > cap) ? cap : ramp;
  end
endmodule

// ===== hw/pwm_gen.sv
`include "srv_regs.svh"
module pwm_gen #(
  parameter int PER = `SRV_PWM_PER
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic [3:0] duty,
  // Output
  output logic            pwm
);
  import srv_pkg::*;
  pwm_s q;
  pwm_s n;
  logic [15:0] phase;
  logic [15:0] limit;

  if (PER < `SRV_PWM_STEPS || PER > 1023) begin : g_chk
    $error("pwm_gen: PER out of range");
  end

  always_comb begin
    n = q;
    phase = 16'(q.cnt) * 16'(`SRV_PWM_STEPS);
    limit = (16'(duty) + 16'h0001) * 16'(PER);
    // Period restarts while idle so every run begins on a fresh cycle
    if (!run || q.cnt == 10'(PER - 1)) begin
      n.cnt = 10'h000;
    end else begin
      n.cnt = q.cnt + 10'h001;
    end
    n.pwm = run && (phase < limit);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pwm = q.pwm;
endmodule

// ===== hw/servo_ctl.sv
// Chosen here: the APB register port and the placing of the registers.
`include "srv_regs.svh"
module servo_ctl #(
  parameter int START_TICKS     = `SRV_START_MIN_US,
  parameter int CONV_TICKS      = `SRV_CONV_US,
  parameter int STEP_TICKS      = `SRV_STEP_US,
  parameter int STEP_LONG_TICKS = `SRV_STEP_LONG_US,
  parameter int PWM_PER         = `SRV_PWM_PER
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Potentiometer conversion result
  input  wire logic [7:0]  potentiometer_input,
  // H-bridge drive
  output logic             bridge_fwd,
  output logic             bridge_rev
);
  import srv_pkg::*;

  ctl_s q;
  ctl_s n;

  logic              tick;
  logic              conv;
  logic              setup;
  logic              wr_done;
  logic signed [8:0] diff;
  logic [7:0]        mag;
  logic [3:0]        absd;
  logic              dir_fwd;
  logic [3:0]        map_val;
  logic [3:0]        map_duty;
  logic              pwm;
  logic              running;
  logic              drive_ok;
  tick_cnt_t         step_lim;

  if (START_TICKS < 1 || START_TICKS > 65535 ||
      CONV_TICKS < 1 || CONV_TICKS > 65535 ||
      STEP_TICKS < 1 || STEP_TICKS > 65535 || STEP_LONG_TICKS > 65535 ||
      STEP_LONG_TICKS < 1) begin : g_chk
    $error("servo_ctl: tick count out of range");
  end

  assign diff    = $signed({1'b0, q.target}) - $signed({1'b0, q.cur});
  assign mag     = diff[8] ? 8'(-diff) : diff[7:0];
  assign absd    = (mag > 8'h0F) ? 4'hF : mag[3:0];
  assign dir_fwd = !diff[8];
  assign running = (q.state == ST_START) || (q.state == ST_PRESTOP);

  // Without soft start the top of the table is the fixed drive level
  always_comb begin
    if (!q.opt[`SRV_OPT_SOFT - 2]) begin
      map_val = `SRV_VAL_FULL;
    end else if (q.state == ST_PRESTOP) begin
      map_val = absd;
    end else begin
      map_val = q.tmr;
    end
  end

  duty_map u_map (
    .max_sel ({q.opt[`SRV_OPT_MDH - 2], q.opt[`SRV_OPT_MDL - 2]}),
    .val     (map_val),
    .duty    (map_duty)
  );

  pwm_gen #(
    .PER (PWM_PER)
  ) u_pwm (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (running),
    .duty    (q.duty),
    .pwm     (pwm)
  );

  always_comb begin
    n = q;
    // Pot sampled through two stages; value moves slowly between samples
    n.pot_s1 = potentiometer_input;
    n.pot_s2 = q.pot_s1;

    // Microsecond tick from the trimmed divider
    tick = (q.tb_cnt >= q.trim - 8'h01);
    n.tb_cnt = tick ? 8'h00 : q.tb_cnt + 8'h01;

    // Conversion interval
    conv = 1'b0;
    if (tick) begin
      if (q.conv_cnt >= tick_cnt_t'(CONV_TICKS - 1)) begin
        n.conv_cnt = '0;
        conv = 1'b1;
      end else begin
        n.conv_cnt = q.conv_cnt + 16'h0001;
      end
    end
    if (conv) begin
      if (!q.acquired) begin
        n.cur = q.pot_s2;
        n.acquired = 1'b1;
      end else if (q.cur < q.pot_s2) begin
        n.cur = q.cur + 8'h01;
      end else if (q.cur > q.pot_s2) begin
        n.cur = q.cur - 8'h01;
      end
    end

    // Motor control
    step_lim = q.opt[`SRV_OPT_TORQ - 2] ? tick_cnt_t'(STEP_LONG_TICKS - 1)
                                        : tick_cnt_t'(STEP_TICKS - 1);
    case (q.state)
      ST_IDLE: begin
        n.duty = 4'h0;
      end
      ST_WAIT: begin
        if (tick) begin
          if (q.dly >= tick_cnt_t'(START_TICKS - 1)) begin
            n.state = (absd == 4'h0) ? ST_IDLE : ST_START;
            n.tmr   = 4'h0;
            n.step  = '0;
          end else begin
            n.dly = q.dly + 16'h0001;
          end
        end
      end
      ST_START: begin
        n.duty = map_duty;
        if (absd == 4'h0) begin
          n.state = ST_IDLE;
        end else if (q.opt[`SRV_OPT_SOFT - 2] && q.tmr > absd) begin
          // The timer has just stepped; its new table entry must not reach
          // the bridge, so the old duty carries over into pre-stop
          n.duty  = q.duty;
          n.state = ST_PRESTOP;
        end else if (tick) begin
          if (q.step >= step_lim) begin
            n.step = '0;
            if (q.tmr != 4'hF) begin
              n.tmr = q.tmr + 4'h1;
            end
          end else begin
            n.step = q.step + 16'h0001;
          end
        end
      end
      ST_PRESTOP: begin
        // A stalled unit step keeps its drive; only arrival or a new command stops it
        n.duty = map_duty;
        if (absd == 4'h0) begin
          n.state = ST_IDLE;
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase

    // APB: fixed one-cycle answer, data latched in setup
    setup   = psel && !penable;
    wr_done = psel && penable && q.pready && pwrite;
    n.pready  = setup;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (setup) begin
      case (paddr)
        `SRV_OFS_CMD:  n.prdata = {24'h000000, q.target};
        `SRV_OFS_OPT:  n.prdata = 32'({q.opt, 2'b00});
        `SRV_OFS_TRIM: n.prdata = {24'h000000, q.trim};
        `SRV_OFS_STAT: begin
          n.prdata[`SRV_ST_CUR_LSB +: 8]   = q.cur;
          n.prdata[`SRV_ST_DUTY_LSB +: 4]  = q.duty;
          n.prdata[`SRV_ST_STATE_LSB +: 2] = q.state;
          n.prdata[`SRV_ST_ACQ]            = q.acquired;
          n.prdata[`SRV_ST_TMR_LSB +: 4]   = q.tmr;
        end
        default: n.pslverr = 1'b1;
      endcase
      if (pwrite && paddr == `SRV_OFS_STAT) begin
        n.pslverr = 1'b1;
      end
    end
    if (wr_done && !q.pslverr) begin
      case (paddr)
        `SRV_OFS_CMD: begin
          // Every command restarts the start delay and timer
          n.target = pwdata[7:0];
          n.state  = ST_WAIT;
          n.dly    = '0;
          n.tmr    = 4'h0;
          n.step   = '0;
          n.duty   = 4'h0;
        end
        `SRV_OFS_OPT: n.opt = pwdata[`SRV_OPT_MDH:`SRV_OPT_SOFT];
        `SRV_OFS_TRIM: begin
          // Zero would wrap the divider to one tick per 256 cycles, so it is ignored
          if (pwdata[7:0] != 8'h00) begin
            n.trim = pwdata[7:0];
          end
        end
        default: n.target = q.target;
      endcase
    end

    // A command during drive releases the bridge at once for the new delay
    drive_ok = (n.state == ST_START) || (n.state == ST_PRESTOP);
    n.fwd = running && dir_fwd && pwm && drive_ok;
    n.rev = running && !dir_fwd && pwm && drive_ok;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.cur      <= `SRV_POS_RST;
      q.target   <= `SRV_POS_RST;
      q.opt      <= `SRV_OPT_RST;
      q.trim     <= 8'(`SRV_TICK_CYC);
      q.state    <= ST_IDLE;
    end else begin
      q <= n;
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign bridge_fwd = q.fwd;
  assign bridge_rev = q.rev;
endmodule

// ===== hw/srv_pkg.sv
package srv_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_START,
    ST_PRESTOP
  } drive_state_e;

  typedef logic [15:0] tick_cnt_t;

  typedef struct packed {
    logic [7:0]   pot_s1;
    logic [7:0]   pot_s2;
    logic [7:0]   tb_cnt;
    tick_cnt_t    conv_cnt;
    tick_cnt_t    dly;
    tick_cnt_t    step;
    logic [3:0]   tmr;
    logic [7:0]   target;
    logic [7:0]   cur;
    logic         acquired;
    drive_state_e state;
    logic [3:0]   opt;
    logic [7:0]   trim;
    logic [3:0]   duty;
    logic         fwd;
    logic         rev;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } ctl_s;

  typedef struct packed {
    logic [9:0] cnt;
    logic       pwm;
  } pwm_s;
endpackage

// ===== hw/srv_regs.svh
`ifndef SRV_REGS_SVH
`define SRV_REGS_SVH

// Register byte offsets
`define SRV_OFS_CMD      8'h00
`define SRV_OFS_OPT      8'h04
`define SRV_OFS_TRIM     8'h08
`define SRV_OFS_STAT     8'h0C

// Drive option field positions, laid out as in the command frame
`define SRV_OPT_SOFT     2
`define SRV_OPT_TORQ     3
`define SRV_OPT_MDL      4
`define SRV_OPT_MDH      5

// Status field positions
`define SRV_ST_CUR_LSB   0
`define SRV_ST_DUTY_LSB  8
`define SRV_ST_STATE_LSB 12
`define SRV_ST_ACQ       14
`define SRV_ST_TMR_LSB   16

// Reset values
`define SRV_POS_RST      8'h00
`define SRV_OPT_RST      4'h0

// Timing: clock, tick of one microsecond, times in microseconds
`define SRV_CLK_HZ       10000000
`define SRV_TICK_HZ      1000000
`define SRV_TICK_CYC     (`SRV_CLK_HZ / `SRV_TICK_HZ)
`define SRV_START_MIN_US 416
`define SRV_START_MAX_US 1250
`define SRV_CONV_US      833
`define SRV_ACQ_MAX_US   7500
`define SRV_STEP_US      15625
`define SRV_STEP_LONG_US 31250
`define SRV_PWM_HZ       19200
`define SRV_PWM_PER      (`SRV_CLK_HZ / `SRV_PWM_HZ)
`define SRV_PWM_STEPS    16

// Duty codes
`define SRV_VAL_FULL     4'hF
`define SRV_DUTY_BASE    4'h2
`define SRV_CAP_00       4'hF
`define SRV_CAP_01       4'hA
`define SRV_CAP_10       4'h6
`define SRV_CAP_11       4'h3
`endif

// ===== sim/motor_model.sv
module motor_model (
  // Clock
  input  wire logic       pclk,
  // Bridge drive and mechanics
  input  wire logic       fwd,
  input  wire logic       rev,
  input  wire logic       stall,
  // Potentiometer
  input  wire logic [7:0] start,
  input  wire logic [7:0] offs,
  output logic [7:0]      pot
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pos = 8'h00;
  logic [1:0] cnt = 2'h0;

  // Shaft moves one count per four driven cycles unless held
  always @(posedge pclk) begin
    if (!stall && (fwd || rev)) begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3) begin
        pos <= fwd ? pos + 8'h01 : pos - 8'h01;
      end
    end
  end
  assign pot = start + pos + offs;
endmodule

// ===== sim/servo_ctl_assertions.sv
module servo_ctl_assertions #(
  parameter int START_TICKS = 416
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  potentiometer_input,
  input wire logic        bridge_fwd,
  input wire logic        bridge_rev
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] since_q;
  logic        cmd_wr;
  assign cmd_wr = psel && penable && pready && pwrite && paddr == 8'h00;
  sequence setup_s;
    psel && !penable;
  endsequence
  // Cycles since the last command; ticks are never shorter than a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_q <= 16'h0000;
    else if (cmd_wr) since_q <= 16'h0000;
    else if (since_q != 16'hFFFF) since_q <= since_q + 16'h0001;
  end
  a_start_delay: assert property ((bridge_fwd || bridge_rev) |->
    since_q >= START_TICKS) else $error("drive began too early");
  a_bridge_excl: assert property (!(bridge_fwd && bridge_rev))
    else $error("both bridge sides driven");
  a_apb_answer: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_err_unmap: assert property (setup_s ##0 (paddr > 8'h0C) |=>
    pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_stat_ro: assert property (setup_s ##0 (pwrite && paddr == 8'h0C)
    |=> pslverr) else $error("status write accepted");
  a_good_ok: assert property (setup_s ##0 (paddr[1:0] == 2'h0 &&
    paddr <= 8'h08) |=> !pslverr) else $error("legal access refused");
endmodule

bind servo_ctl servo_ctl_assertions #(.START_TICKS(START_TICKS))
  servo_ctl_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .potentiometer_input(potentiometer_input), .bridge_fwd(bridge_fwd),
  .bridge_rev(bridge_rev));

// ===== sim/tb_servo_ctl.sv
module tb_servo_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pot;
  logic        fwd;
  logic        rev;
  logic        stall = 1'b1;
  logic [7:0]  start = 8'h00;
  logic [7:0]  offs = 8'h00;
  logic [7:0]  base;
  logic [64:0] ent;
  logic [64:0] expq[$];
  logic [3:0]  dt[4] = '{4'hF, 4'hA, 4'h6, 4'h3};
  int          err_count = 0;
  int          num_checks = 0;
  int          s;
  int          n;

  servo_ctl #(.START_TICKS(4), .CONV_TICKS(8), .STEP_TICKS(20),
    .STEP_LONG_TICKS(40), .PWM_PER(32)) servo_ctl_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .potentiometer_input(pot), .bridge_fwd(fwd),
    .bridge_rev(rev));
  motor_model motor_model_inst (.pclk(pclk), .fwd(fwd), .rev(rev),
    .stall(stall), .start(start), .offs(offs), .pot(pot));

  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read data d is compared under mask m; writes compare only the error
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, m, input logic e);
    int k = 0;
    @(posedge pclk);
    expq.push_back({e, w ? 32'h0 : m, w ? 32'h0 : d & m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 8) begin
      err_count++;
      stop_test();
    end
  endtask

  function automatic logic [31:0] st(logic [3:0] tm, logic [1:0] sv,
                                     logic [3:0] du, logic [7:0] c);
    return {12'h0, tm, 2'b01, sv, du, c};
  endfunction

  task automatic wait_drv(input logic r);
    int k = 0;
    // Sampled on the falling edge, where the bridge outputs have settled
    do begin
      @(negedge pclk);
      k++;
    end while ((r ? rev : fwd) !== 1'b1 && k < 200);
    check("drive delay", k >= 4 && k <= 15, 1);
    if (k >= 200) stop_test();
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && expq.size() > 0) begin
      ent = expq.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, ent[64]});
      check("prdata", prdata & ent[63:32], ent[31:0]);
    end
  end

  initial begin
    void'($urandom(32'hC963));
    start = 8'h20 + 8'($urandom() % 176);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h0C, 32'h0, 32'h70FF, 0);
    apb(0, 8'h08, 32'h0A, 32'hFF, 0);
    apb(0, 8'h04, 32'h0, 32'h3C, 0);
    apb(0, 8'h10, 32'h0, 32'hFFFFFFFF, 1);
    apb(1, 8'h0C, 32'h0, 32'h0, 1);
    apb(1, 8'h08, 32'h1, 32'h0, 0);
    repeat (20) @(posedge pclk);
    apb(0, 8'h0C, st(0, 0, 0, start), 32'h70FF, 0);
    offs <= 8'h06;
    base = start + 8'h06;
    repeat (70) @(posedge pclk);
    apb(0, 8'h0C, st(0, 0, 0, base), 32'h70FF, 0);
    for (int t = 0; t < 2; t++) begin
      s = 20 * (t + 1);
      apb(1, 8'h04, t ? 32'h0C : 32'h04, 32'h0, 0);
      apb(1, 8'h00, {24'h0, base + 8'h01}, 32'h0, 0);
      wait_drv(0);
      repeat (s / 2) @(posedge pclk);
      apb(0, 8'h0C, st(0, 2, 2, base), 32'hF7FFF, 0);
      repeat (s - 3) @(posedge pclk);
      apb(0, 8'h0C, st(1, 2, 3, base), 32'hF7FFF, 0);
      repeat (s - 3) @(posedge pclk);
      apb(0, 8'h0C, st(2, 3, 3, base), 32'hF7FFF, 0);
      repeat (2 * s) @(posedge pclk);
      apb(0, 8'h0C, st(0, 3, 3, base), 32'h7FFF, 0);
    end
    stall <= 1'b0;
    apb(1, 8'h00, {24'h0, base + 8'h01}, 32'h0, 0);
    wait_drv(0);
    repeat (60) @(posedge pclk);
    check("fwd stop", {31'h0, fwd}, 32'h0);
    base = base + 8'h01;
    apb(0, 8'h0C, st(0, 0, 0, base), 32'h30FF, 0);
    stall <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1, 8'h04, i << 4, 32'h0, 0);
      apb(1, 8'h00, {24'h0, i[0] ? base - 8'h05 : base + 8'h05}, 0, 0);
      wait_drv(i[0]);
      n = 0;
      for (int k = 0; k < 32; k++) begin
        n += i[0] ? rev : fwd;
        @(negedge pclk);
      end
      check("high cycles", n, 2 * (dt[i] + 1));
      apb(0, 8'h0C, st(0, 2, dt[i], 0), 32'h3F00, 0);
    end
    stop_test();
  end
endmodule
